/* File: omc_operating_config.sv */
// Behaviour
// - bit 0 set bypasses the high-pass filters of all current inputs.
// - bit 1 set bypasses the low-pass filters after the power multipliers.
// - bit 2 set holds both pulse outputs still; it resets to one.
// - bits 3 to 5 are the converter mode, reset zero, zero is normal.
// - mode 100 swaps voltage and current input routing.
// - mode 001 powers off the current converters only.
// - mode 101 powers off current converters, current into voltage path.
// - mode 010 powers off the voltage converters only.
// - mode 110 powers off voltage converters, voltage into current path.
// - mode 011 enters sleep.
// - mode 111 enters power-down.
// - writing one to bit 6 triggers a whole-chip software reset.
// - registers sit at seven-bit addresses reached via the serial port.
`include "omc_cfg.svh"
module omc_operating_config #(
  parameter int HOLDOFF_CYC = `OMC_SOFT_CHIP_RESET_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [`OMC_ADDR_W-1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  output logic o_rd_hit,
  input wire logic i_active_pulse,
  input wire logic i_reactive_pulse,
  output logic o_active_pulse_out,
  output logic o_reactive_pulse_out,
  output logic o_hipass_bypass,
  output logic o_lowpass_bypass,
  output logic o_cur_adc_off,
  output logic o_volt_adc_off,
  output logic o_route_volt_to_cur,
  output logic o_route_cur_to_volt,
  output logic o_sleep,
  output logic o_power_down,
  output logic o_chip_reset,
  output logic o_holdoff
);
  logic [7:0] operating_config_reg;
  logic sel;
  logic trig_reg;
  logic chip_reset;
  logic [7:0] rd_data_reg;
  logic rd_hit_reg;
  logic act_reg;
  logic react_reg;

  assign sel = (i_addr == `OMC_ADDR_OPCFG);

  always_ff @(posedge i_clk) begin
    if (i_reset || chip_reset) begin
      operating_config_reg <= `OMC_RESET_VAL;
    end else if (i_wr_en && sel) begin
      operating_config_reg <= i_wr_data;
    end else if (operating_config_reg[`OMC_BIT_SOFT_CHIP_RESET]) begin
      operating_config_reg[`OMC_BIT_SOFT_CHIP_RESET] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= i_wr_en && sel && i_wr_data[`OMC_BIT_SOFT_CHIP_RESET];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_data_reg <= 8'h00;
      rd_hit_reg <= 1'b0;
    end else begin
      rd_hit_reg <= i_rd_en && sel;
      rd_data_reg <= (i_rd_en && sel) ? operating_config_reg : 8'h00;
    end
  end
  assign o_rd_data = rd_data_reg;
  assign o_rd_hit = rd_hit_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset || chip_reset) begin
      act_reg <= 1'b0;
      react_reg <= 1'b0;
    end else if (operating_config_reg[`OMC_BIT_CFGATE]) begin
      act_reg <= act_reg;
      react_reg <= react_reg;
    end else begin
      act_reg <= i_active_pulse;
      react_reg <= i_reactive_pulse;
    end
  end
  assign o_active_pulse_out = act_reg;
  assign o_reactive_pulse_out = react_reg;

  assign o_hipass_bypass = operating_config_reg[`OMC_BIT_HPF];
  assign o_lowpass_bypass = operating_config_reg[`OMC_BIT_LPF];

  omc_mode_decode u_decode (
    .i_mode(operating_config_reg[`OMC_MODE_HI:`OMC_MODE_LO]),
    .o_cur_adc_off(o_cur_adc_off),
    .o_volt_adc_off(o_volt_adc_off),
    .o_route_volt_to_cur(o_route_volt_to_cur),
    .o_route_cur_to_volt(o_route_cur_to_volt),
    .o_sleep(o_sleep),
    .o_power_down(o_power_down)
  );

  omc_reset_seq #(
    .HOLDOFF_CYC(HOLDOFF_CYC)
  ) u_reset (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_trigger(trig_reg),
    .o_chip_reset(chip_reset),
    .o_holdoff(o_holdoff)
  );
  assign o_chip_reset = chip_reset;
endmodule : omc_operating_config

/* File: omc_cfg.svh */
`ifndef OMC_CFG_SVH
`define OMC_CFG_SVH
`define OMC_ADDR_W 7
`define OMC_ADDR_OPCFG 7'h13
`define OMC_BIT_HPF 0
`define OMC_BIT_LPF 1
`define OMC_BIT_CFGATE 2
`define OMC_MODE_LO 3
`define OMC_MODE_HI 5
`define OMC_BIT_SOFT_CHIP_RESET 6
`define OMC_BIT_RSVD 7
`define OMC_RESET_VAL 8'h04
`define OMC_CLK_MHZ 250
`define OMC_SOFT_CHIP_RESET_US 166
`define OMC_SOFT_CHIP_RESET_CYC (`OMC_SOFT_CHIP_RESET_US * `OMC_CLK_MHZ)
`define OMC_RST_PULSE 4
`endif

/* File: omc_pkg.sv */
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_NORMAL = 3'b000,
    OMC_CUR_OFF = 3'b001,
    OMC_VOLT_OFF = 3'b010,
    OMC_SLEEP = 3'b011,
    OMC_SWAP = 3'b100,
    OMC_CUR_OFF_REDIR = 3'b101,
    OMC_VOLT_OFF_REDIR = 3'b110,
    OMC_POWER_DOWN = 3'b111
  } omc_conv_mode_t;
  typedef enum logic [1:0] {
    OMC_RUN = 2'b00,
    OMC_RESETTING = 2'b01,
    OMC_HOLDOFF = 2'b10
  } omc_rst_state_t;
endpackage : omc_pkg

/* File: omc_mode_decode.sv */
`include "omc_cfg.svh"
module omc_mode_decode (
  input wire logic [2:0] i_mode,
  output logic o_cur_adc_off,
  output logic o_volt_adc_off,
  output logic o_route_volt_to_cur,
  output logic o_route_cur_to_volt,
  output logic o_sleep,
  output logic o_power_down
);
  always_comb begin
    o_cur_adc_off = 1'b0;
    o_volt_adc_off = 1'b0;
    o_route_volt_to_cur = 1'b0;
    o_route_cur_to_volt = 1'b0;
    o_sleep = 1'b0;
    o_power_down = 1'b0;
    case (omc_pkg::omc_conv_mode_t'(i_mode))
      omc_pkg::OMC_NORMAL: begin
      end
      omc_pkg::OMC_SWAP: begin
        o_route_volt_to_cur = 1'b1;
        o_route_cur_to_volt = 1'b1;
      end
      omc_pkg::OMC_CUR_OFF: begin
        o_cur_adc_off = 1'b1;
      end
      omc_pkg::OMC_CUR_OFF_REDIR: begin
        o_cur_adc_off = 1'b1;
        o_route_cur_to_volt = 1'b1;
      end
      omc_pkg::OMC_VOLT_OFF: begin
        o_volt_adc_off = 1'b1;
      end
      omc_pkg::OMC_VOLT_OFF_REDIR: begin
        o_volt_adc_off = 1'b1;
        o_route_volt_to_cur = 1'b1;
      end
      omc_pkg::OMC_SLEEP: begin
        o_sleep = 1'b1;
      end
      omc_pkg::OMC_POWER_DOWN: begin
        o_power_down = 1'b1;
        o_cur_adc_off = 1'b1;
        o_volt_adc_off = 1'b1;
      end
      default: begin
      end
    endcase
  end
endmodule : omc_mode_decode

/* File: omc_reset_seq.sv */
`include "omc_cfg.svh"
module omc_reset_seq #(
  parameter int HOLDOFF_CYC = `OMC_SOFT_CHIP_RESET_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_trigger,
  output logic o_chip_reset,
  output logic o_holdoff
);
  omc_pkg::omc_rst_state_t state_reg;
  logic [31:0] count_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= omc_pkg::OMC_RUN;
      count_reg <= 32'h0;
    end else begin
      case (state_reg)
        omc_pkg::OMC_RUN: begin
          if (i_trigger) begin
            state_reg <= omc_pkg::OMC_RESETTING;
            count_reg <= 32'h0;
          end
        end
        omc_pkg::OMC_RESETTING: begin
          if (count_reg == 32'(`OMC_RST_PULSE - 1)) begin
            state_reg <= omc_pkg::OMC_HOLDOFF;
            count_reg <= 32'h0;
          end else begin
            count_reg <= count_reg + 32'h1;
          end
        end
        omc_pkg::OMC_HOLDOFF: begin
          if (count_reg >= 32'(HOLDOFF_CYC - 1)) begin
            state_reg <= omc_pkg::OMC_RUN;
          end else begin
            count_reg <= count_reg + 32'h1;
          end
        end
        default: state_reg <= omc_pkg::OMC_RUN;
      endcase
    end
  end
  assign o_chip_reset = (state_reg == omc_pkg::OMC_RESETTING);
  assign o_holdoff = (state_reg != omc_pkg::OMC_RUN);
endmodule : omc_reset_seq

/* File: omc_checker_assertions.sv */
module omc_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [6:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_hit,
  input wire logic o_active_pulse_out,
  input wire logic o_reactive_pulse_out,
  input wire logic o_hipass_bypass,
  input wire logic o_cur_adc_off,
  input wire logic o_volt_adc_off,
  input wire logic o_route_volt_to_cur,
  input wire logic o_sleep,
  input wire logic o_power_down,
  input wire logic o_chip_reset,
  input wire logic o_holdoff
);
  logic [7:0] m;
  logic w;
  logic c;
  assign c = o_chip_reset;
  assign w = i_wr_en && i_addr == 7'h13 && !c;
  // mirror of the stored byte, reset bit never kept
  always_ff @(posedge i_clk) begin
    if (i_reset || c) begin
      m <= 8'h04;
    end else if (w) begin
      m <= i_wr_data & 8'hBF;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_hipass_follow: assert property (!c |-> o_hipass_bypass == m[0])
    else $error("hipass bypass wrong");
  a_pulse_hold: assert property ($past(m[2]) && !c && !$past(c)
    |-> $stable(o_active_pulse_out) && $stable(o_reactive_pulse_out))
    else $error("pulse not held");
  a_adc_off: assert property (!c && m[5:3] != 3'b011
    |-> o_cur_adc_off == m[3] && o_volt_adc_off == m[4])
    else $error("adc off wrong");
  a_route_swap: assert property (!c && m[5:3] != 3'b111
    |-> o_route_volt_to_cur == (m[5] && !m[3])) else $error("route wrong");
  a_sleep_mode: assert property (!c |->
    o_sleep == (m[5:3] == 3'b011) && o_power_down == &m[5:3])
    else $error("sleep wrong");
  a_soft_chip_reset_pulse: assert property (w && i_wr_data[6]
    |=> ##1 c [*4] ##1 !c) else $error("chip reset pulse wrong");
  a_rd_hit: assert property (i_rd_en && i_addr == 7'h13
    |=> o_rd_hit && o_rd_data == $past(m)) else $error("read wrong");
  a_rd_idle: assert property (!(i_rd_en && i_addr == 7'h13)
    |=> !o_rd_hit && o_rd_data == 8'h00) else $error("read not idle");
  a_holdoff_span: assert property ((c || $past(c)) |-> o_holdoff)
    else $error("holdoff low around chip reset");
endmodule : omc_checker
bind omc_operating_config omc_checker u_chk (.*);

/* File: omc_host.sv */
module omc_host (
  input wire logic i_clk,
  input wire logic i_holdoff,
  input wire logic [7:0] i_rd_data,
  output logic [6:0] o_addr = 7'h00,
  output logic o_wr_en = 1'b0,
  output logic [7:0] o_wr_data = 8'h00,
  output logic o_rd_en = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr_data <= d & 8'h7F;
    o_wr_en <= 1'b1;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
    o_addr <= ~a;
    repeat (3) @(posedge i_clk);
    while (i_holdoff === 1'b1) @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rd_data;
  endtask : rd
endmodule : omc_host

/* File: operating_mode_control_tb.sv */
`include "omc_cfg.svh"
module operating_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD_CYC = 20;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_active_pulse = 1'b0;
  logic i_reactive_pulse = 1'b0;
  logic i_wr_en, i_rd_en, o_rd_hit, o_active_pulse_out, o_reactive_pulse_out;
  logic o_hipass_bypass, o_lowpass_bypass, o_cur_adc_off, o_volt_adc_off;
  logic o_route_volt_to_cur, o_route_cur_to_volt, o_sleep, o_power_down;
  logic o_chip_reset, o_holdoff;
  logic [6:0] i_addr;
  logic [7:0] i_wr_data, o_rd_data, d;
  logic [5:0] tbl [8] = '{6'h00, 6'h20, 6'h10, 6'h02, 6'h0C, 6'h24, 6'h18,
    6'h31};
  int error_cnt = 0;
  int check_count = 0;
  always #2 i_clk = ~i_clk;
  omc_operating_config #(.HOLDOFF_CYC(HOLD_CYC)) u_dut (.*);
  omc_host u_host (.i_clk(i_clk), .i_holdoff(o_holdoff),
    .i_rd_data(o_rd_data), .o_addr(i_addr), .o_wr_en(i_wr_en),
    .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic t_regs;
    u_host.rd(7'h13, d);
    chk("reset", 8'h04, d);
    u_host.wr(7'h13, 8'h07);
    u_host.wr(7'h14, 8'hFF);
    chk("bypass", 8'h03,
      {6'h00, o_lowpass_bypass, o_hipass_bypass});
    u_host.rd(7'h14, d);
    chk("other", 8'h00, d);
    u_host.rd(7'h13, d);
    chk("cfg", 8'h07, d);
  endtask : t_regs
  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      u_host.wr(7'h13, {2'b00, 3'(i), 3'b100});
      chk("mode", {2'b00, tbl[i]},
        {2'b00, o_cur_adc_off, o_volt_adc_off,
        o_route_volt_to_cur, o_route_cur_to_volt,
        o_sleep, o_power_down});
    end
  endtask : t_modes
  task automatic t_pulse;
    u_host.wr(7'h13, 8'h00);
    i_active_pulse <= 1'b1;
    i_reactive_pulse <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk("pass", 8'h03,
      {6'h00, o_active_pulse_out, o_reactive_pulse_out});
    u_host.wr(7'h13, 8'h04);
    i_active_pulse <= 1'b0;
    i_reactive_pulse <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk("gate", 8'h03,
      {6'h00, o_active_pulse_out, o_reactive_pulse_out});
  endtask : t_pulse
  task automatic t_soft_chip_reset;
    int n = 0;
    fork
      u_host.wr(7'h13, 8'h43);
      begin
        @(posedge o_holdoff);
        @(negedge i_clk);
        while (o_holdoff === 1'b1) begin
          n++;
          @(negedge i_clk);
        end
      end
    join
    chk("holdoff", 8'(`OMC_RST_PULSE + HOLD_CYC), 8'(n));
    u_host.rd(7'h13, d);
    chk("soft_chip_reset", 8'h04, d);
  endtask : t_soft_chip_reset
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_modes();
    t_pulse();
    t_soft_chip_reset();
    finish_test();
  end
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule : operating_mode_control_tb
